// ===== inc/iie_pkg.sv
// ---------------------------------------------------------------------
// Constants for the isolated input event block
// ---------------------------------------------------------------------
package iie_pkg;

  // Geometry
  localparam int NUM_PORTS = 4;
  localparam int PORT_W    = 8;
  localparam int NUM_LINES = NUM_PORTS * PORT_W;
  localparam int NIB_N     = NUM_LINES / 4;

  // Word offsets (byte address) of the bank ports and fixed registers
  localparam logic [7:0] OFS_PORT0   = 8'h00;
  localparam logic [7:0] OFS_PORT7   = 8'h1c;
  localparam logic [7:0] OFS_IER     = 8'h20;
  localparam logic [7:0] OFS_IVR     = 8'h24;

  // Port indices inside a bank
  localparam logic [2:0] P_DB_CTRL   = 3'h0;
  localparam logic [2:0] P_DB_DUR0   = 3'h1;
  localparam logic [2:0] P_DB_CLK    = 3'h3;
  localparam logic [2:0] P_POLARITY  = 3'h6;
  localparam logic [2:0] P_BANK      = 3'h7;

  // Field positions
  localparam int BANK_LSB    = 6;
  localparam int IER_EN_BIT  = 0;
  localparam int IER_SRST_BIT = 1;
  localparam logic [5:0] IER_UNUSED_RD = 6'h3f;

  // Bank codes
  typedef enum logic [1:0] {
    IIE_BANK_LEVEL = 2'b00,
    IIE_BANK_EVENT = 2'b01,
    IIE_BANK_DEB   = 2'b10,
    IIE_BANK_BAD   = 2'b11
  } iie_bank_t;

  // Unlock sequence progress
  typedef enum logic [2:0] {
    IIE_UL_IDLE = 3'b000,
    IIE_UL_B1   = 3'b001,
    IIE_UL_B2   = 3'b010,
    IIE_UL_B3   = 3'b011,
    IIE_UL_ENH  = 3'b100
  } iie_mode_t;

  localparam logic [7:0] UNLOCK_B0 = 8'h07;
  localparam logic [7:0] UNLOCK_B1 = 8'h0d;
  localparam logic [7:0] UNLOCK_B2 = 8'h06;
  localparam logic [7:0] UNLOCK_B3 = 8'h12;

  // Reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;

  // Clock and debounce windows (upper bound of each window)
  localparam longint CLK_HZ       = 20000000;
  localparam longint DB0_NS       = 4000;
  localparam longint DB1_NS       = 64000;
  localparam longint DB2_NS       = 1000000;
  localparam longint DB3_NS       = 8000000;
  localparam longint DB0_CYC      = DB0_NS * CLK_HZ / 1000000000;
  localparam longint DB1_CYC      = DB1_NS * CLK_HZ / 1000000000;
  localparam int     DB_CNT_W     = 18;

endpackage : iie_pkg

// ===== logic/iie_top.sv
`timescale 1ns/1ps
// What this block does
// - Thirty-two inputs form four eight-bit ports, zero to three.
// - Inputs are non-inverting; an undriven line reads zero.
// - Port read returns eight levels on bits 0-7, high reads one.
// - Unmasked write of 1 forces a line to read 0 until cleared.
// - Enhanced mode has banks: levels, event sense, debounce setup.
// - Event sensing works only in enhanced mode, enabled per channel.
// - Polarity per nibble: positive rising, negative falling edges.
// - Any reset clears, disables detectors and sets positive polarity.
// - Pairing opposite-polarity nibbles gives up to 16 change detectors.
// - With debounce, a level counts only after stable whole window.
// - Debounce timing runs only when its clock select is set.
// - Duration selects one of four windows, 4us to 8ms.
// - Interrupts only in enhanced mode for enabled channels.
// - Writing 0 clears an event flag; writing 1 re-arms it.
// - Request line driven only while enable bit 0 is set.
// - Vector fetch is answered with the stored 8-bit vector.
// - Request released when flag cleared or enable bit 0 cleared.
// - Enhanced bank 0 reads levels, bank 1 reads latched flags.
// - Vector survives software reset, enable takes bit 0 of the reset write, bus reset clears both.
// - Port 7 bits 7:6 pick bank 00 levels, 01 events, 10 debounce.
// - Enable bit 1 triggers software reset, is not stored, reads 0.
// - Any reset returns standard mode and clears the write mask.
module iie_top
  import iie_pkg::*;
#(
  parameter int DB2_CYC = 20000,
  parameter int DB3_CYC = 160000
)
(
  // Clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  // Wishbone slave
  input  wire logic                       CYC_I,
  input  wire logic                       STB_I,
  input  wire logic                       WE_I,
  input  wire logic [7:0]                 ADR_I,
  input  wire logic [3:0]                 SEL_I,
  input  wire logic [31:0]                DAT_I,
  output logic      [31:0]                DAT_O,
  output logic                            ACK_O,
  // Field inputs, first_input_line is bit 0, last_input_line bit 31
  input  wire logic [iie_pkg::NUM_LINES-1:0] IN_LINES,
  // Interrupt request and vector_fetch_cycle
  output logic                            IRQ_N,
  input  wire logic                       VEC_FETCH,
  output logic      [7:0]                 VEC_DATA,
  output logic                            VEC_ACK
);
  import iie_pkg::*;

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  iie_mode_t              mode_r, mode_nxt;
  iie_bank_t              bank_r, bank_nxt;
  logic [NUM_PORTS-1:0]   wmask_r, wmask_nxt;
  logic [NUM_LINES-1:0]   force_r, force_nxt;
  logic [NUM_LINES-1:0]   ev_en_r, ev_en_nxt;
  logic [NUM_LINES-1:0]   flag_r, flag_nxt;
  logic [NIB_N-1:0]       pol_r, pol_nxt;
  logic [NUM_PORTS-1:0]   db_ctl_r, db_ctl_nxt;
  logic [7:0]             db_dur_r, db_dur_nxt;
  logic                   db_clk_r, db_clk_nxt;
  logic                   ier_en_r;
  logic [7:0]             ivr_r;
  logic                   ack_r;
  logic [31:0]            dat_r;
  logic                   irq_n_r;
  logic [7:0]             vec_r;
  logic                   vack_r;
  logic [NUM_LINES-1:0]   stable;
  logic [NUM_LINES-1:0]   prev_r;

  // -------------------------------------------------------------------
  // Bus decode
  // -------------------------------------------------------------------
  wire        req      = CYC_I & STB_I & ~ack_r;
  wire        wr       = req & WE_I & SEL_I[0];
  wire        rd       = req & ~WE_I;
  // Address bits 1:0 are ignored, every register is one word
  wire        in_bank  = ADR_I[7:2] <= OFS_PORT7[7:2];
  wire [2:0]  port     = ADR_I[4:2];
  wire        hit_ier  = ADR_I[7:2] == OFS_IER[7:2];
  wire        hit_ivr  = ADR_I[7:2] == OFS_IVR[7:2];
  wire [7:0]  wdat     = DAT_I[7:0];
  wire        enh      = mode_r == IIE_UL_ENH;
  wire        bank_acc = req & in_bank;
  wire        soft_rst = wr & hit_ier & wdat[IER_SRST_BIT];
  wire        wr_p7    = wr & in_bank & (port == P_BANK);
  wire        wr_lvl   = wr & in_bank & (~enh | bank_r == IIE_BANK_LEVEL);
  wire        wr_ev    = wr & in_bank & enh & bank_r == IIE_BANK_EVENT;
  wire        wr_db    = wr & in_bank & enh & bank_r == IIE_BANK_DEB;

  // Line value seen by software: filtered level with forced-low lines
  wire [NUM_LINES-1:0] level = stable & ~force_r;

  // -------------------------------------------------------------------
  // Debounce, one filter per line
  // -------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++)
    begin : g_line
      localparam int PRT = gi / PORT_W;
      logic [DB_CNT_W-1:0] cnt_r;
      logic                stab_r;
      logic [1:0]          dsel;
      logic [DB_CNT_W-1:0] lim;
      logic                on;
      assign dsel = db_dur_r[2*PRT +: 2];
      assign on   = enh & db_clk_r & db_ctl_r[PRT];
      // Window upper bound, so the guarantee holds for the whole span
      assign lim  = (dsel == 2'd0) ? DB_CNT_W'(DB0_CYC) :
                    (dsel == 2'd1) ? DB_CNT_W'(DB1_CYC) :
                    (dsel == 2'd2) ? DB_CNT_W'(DB2_CYC) :
                                     DB_CNT_W'(DB3_CYC);
      assign stable[gi] = on ? stab_r : IN_LINES[gi];
      // Counts consecutive cycles that differ from the accepted level
      always_ff @(posedge CLK or negedge RST_N)
      begin
        if (!RST_N)
        begin
          cnt_r  <= '0;
          stab_r <= 1'b0;
        end
        else if (!on || IN_LINES[gi] == stab_r || soft_rst)
        begin
          cnt_r  <= '0;
          stab_r <= on ? stab_r : IN_LINES[gi];
        end
        else if (cnt_r >= lim - DB_CNT_W'(1))
        begin
          cnt_r  <= '0;
          stab_r <= IN_LINES[gi];
        end
        else
        begin
          cnt_r  <= cnt_r + DB_CNT_W'(1);
        end
      end
    end
  endgenerate

  // -------------------------------------------------------------------
  // Edge detection per channel
  // -------------------------------------------------------------------
  wire [NUM_LINES-1:0] pol_neg;
  generate
    for (gi = 0; gi < NUM_LINES; gi++)
    begin : g_pol
      assign pol_neg[gi] = pol_r[gi / 4];
    end
  endgenerate
  wire [NUM_LINES-1:0] rise = stable & ~prev_r;
  wire [NUM_LINES-1:0] fall = ~stable & prev_r;
  wire [NUM_LINES-1:0] edge_hit =
    ((rise & ~pol_neg) | (fall & pol_neg)) & ev_en_r & {NUM_LINES{enh}};

  // -------------------------------------------------------------------
  // Next-state logic for the configuration and unlock
  // -------------------------------------------------------------------
  always_comb
  begin
    mode_nxt   = mode_r;
    bank_nxt   = bank_r;
    wmask_nxt  = wmask_r;
    force_nxt  = force_r;
    ev_en_nxt  = ev_en_r;
    pol_nxt    = pol_r;
    db_ctl_nxt = db_ctl_r;
    db_dur_nxt = db_dur_r;
    db_clk_nxt = db_clk_r;
    // Unlock walk; any stray access restarts it
    if (!enh && req)
    begin
      if (wr_p7 && mode_r == IIE_UL_IDLE && wdat == UNLOCK_B0)
        mode_nxt = IIE_UL_B1;
      else if (wr_p7 && mode_r == IIE_UL_B1 && wdat == UNLOCK_B1)
        mode_nxt = IIE_UL_B2;
      else if (wr_p7 && mode_r == IIE_UL_B2 && wdat == UNLOCK_B2)
        mode_nxt = IIE_UL_B3;
      else if (wr_p7 && mode_r == IIE_UL_B3 && wdat == UNLOCK_B3)
        mode_nxt = IIE_UL_ENH;
      else
        mode_nxt = IIE_UL_IDLE;
    end
    // Bank select; code 11 is refused and the bank stays
    if (enh && wr_p7 && wdat[7:6] != IIE_BANK_BAD)
      bank_nxt = iie_bank_t'(wdat[7:6]);
    // Mask rides on a bank-0 code: a refused code leaves it alone,
    // and leaving bank 0 does not wipe it
    if (enh && wr_p7 && wdat[7:6] == IIE_BANK_LEVEL)
      wmask_nxt = wdat[NUM_PORTS-1:0];
    // Unmasked writes drive the forced-low latches
    if (wr_lvl && port < 3'(NUM_PORTS) && !wmask_r[port[1:0]])
      force_nxt[port[1:0]*PORT_W +: PORT_W] = wdat;
    if (wr_ev && port < 3'(NUM_PORTS))
      ev_en_nxt[port[1:0]*PORT_W +: PORT_W] = wdat;
    if (wr_ev && port == P_POLARITY)
      pol_nxt = wdat;
    if (wr_db && port == P_DB_CTRL)
      db_ctl_nxt = wdat[NUM_PORTS-1:0];
    if (wr_db && port == P_DB_DUR0)
      db_dur_nxt = wdat;
    if (wr_db && port == P_DB_CLK)
      db_clk_nxt = wdat[0];
  end

  // Flags: an edge in the clearing cycle still lands
  wire [NUM_LINES-1:0] clr_mask = wr_ev && port < 3'(NUM_PORTS) ?
    ~({{(NUM_LINES-PORT_W){1'b0}}, ~wdat} << (port[1:0]*PORT_W)) :
    {NUM_LINES{1'b1}};
  assign flag_nxt = edge_hit | (flag_r & clr_mask);

  // -------------------------------------------------------------------
  // Read mux
  // -------------------------------------------------------------------
  wire [7:0] lvl_b  = level[port[1:0]*PORT_W +: PORT_W];
  wire [7:0] flg_b  = flag_r[port[1:0]*PORT_W +: PORT_W];
  wire [7:0] p7_b   = {bank_r, 2'b00,
                       bank_r == IIE_BANK_LEVEL ? wmask_r : 4'h0};
  wire [7:0] deb_b  = port == P_DB_CTRL ? {4'h0, db_ctl_r} :
                      port == P_DB_DUR0 ? db_dur_r :
                      port == P_DB_CLK  ? {7'h00, db_clk_r} : 8'h00;
  wire [7:0] bank_b =
    !enh ? (port < 3'(NUM_PORTS) ? lvl_b : 8'h00) :
    port == P_BANK ? p7_b :
    bank_r == IIE_BANK_LEVEL ? (port < 3'(NUM_PORTS) ? lvl_b : 8'h00) :
    bank_r == IIE_BANK_EVENT ? (port < 3'(NUM_PORTS) ? flg_b : 8'h00) :
    deb_b;
  wire [7:0] rd_b   = in_bank ? bank_b :
                      hit_ier ? {IER_UNUSED_RD, 1'b0, ier_en_r} :
                      hit_ivr ? ivr_r : 8'h00;
  wire       irq_lvl = ier_en_r & enh & (|flag_r);
  // A fetch is answered only while the request line already stands low
  wire       vec_take = VEC_FETCH & ~irq_n_r & ~vack_r;

  // -------------------------------------------------------------------
  // Registers cleared by any reset, software reset included, except prev_r, which software reset loads from stable
  // -------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mode_r   <= IIE_UL_IDLE;
      bank_r   <= IIE_BANK_LEVEL;
      wmask_r  <= '0;
      force_r  <= '0;
      ev_en_r  <= '0;
      flag_r   <= '0;
      pol_r    <= '0;
      db_ctl_r <= '0;
      db_dur_r <= RST_BYTE;
      db_clk_r <= 1'b0;
      prev_r   <= '0;
    end
    else if (soft_rst)
    begin
      mode_r   <= IIE_UL_IDLE;
      bank_r   <= IIE_BANK_LEVEL;
      wmask_r  <= '0;
      force_r  <= '0;
      ev_en_r  <= '0;
      flag_r   <= '0;
      pol_r    <= '0;
      db_ctl_r <= '0;
      db_dur_r <= RST_BYTE;
      db_clk_r <= 1'b0;
      prev_r   <= stable;
    end
    else
    begin
      mode_r   <= mode_nxt;
      bank_r   <= bank_nxt;
      wmask_r  <= wmask_nxt;
      force_r  <= force_nxt;
      ev_en_r  <= ev_en_nxt;
      flag_r   <= flag_nxt;
      pol_r    <= pol_nxt;
      db_ctl_r <= db_ctl_nxt;
      db_dur_r <= db_dur_nxt;
      db_clk_r <= db_clk_nxt;
      prev_r   <= stable;
    end
  end

  // -------------------------------------------------------------------
  // Interrupt control and vector; software reset keeps the vector, the enable takes bit 0 of the reset write
  // -------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ier_en_r <= 1'b0;
      ivr_r    <= RST_BYTE;
    end
    else
    begin
      if (wr && hit_ier)
        ier_en_r <= wdat[IER_EN_BIT];
      if (wr && hit_ivr)
        ivr_r <= wdat;
    end
  end

  // Bus answer, request line and vector answer, all registered
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ack_r   <= 1'b0;
      dat_r   <= RST_WORD;
      irq_n_r <= 1'b1;
      vec_r   <= RST_BYTE;
      vack_r  <= 1'b0;
    end
    else
    begin
      ack_r   <= CYC_I & STB_I & ~ack_r;
      dat_r   <= rd ? {24'h000000, rd_b} : RST_WORD;
      irq_n_r <= ~irq_lvl;
      vack_r  <= vec_take;
      vec_r   <= vec_take ? ivr_r : RST_BYTE;
    end
  end

  assign DAT_O    = dat_r;
  assign ACK_O    = ack_r;
  assign IRQ_N    = irq_n_r;
  assign VEC_DATA = vec_r;
  assign VEC_ACK  = vack_r;

endmodule : iie_top

// ===== test/iie_top_chk.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port checker
// ------------------------------------------------------------
module iie_top_chk
  import iie_pkg::*;
#(
  parameter int DB2_CYC = 20000,
  parameter int DB3_CYC = 160000
)
(
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // Register bus
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [7:0]  ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  // Interrupt side
  input wire logic        IRQ_N,
  input wire logic        VEC_FETCH,
  input wire logic [7:0]  VEC_DATA,
  input wire logic        VEC_ACK
);
  // Request accepted at this edge
  wire take = CYC_I && STB_I && !ACK_O;
  wire interrupt_control_register  = ADR_I[7:2] == OFS_IER[7:2];

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_ack_next_cycle: assert property (take |=> ACK_O)
    else $error("bus request not acknowledged");
  a_no_stray_ack: assert property (!take |=> !ACK_O)
    else $error("ack without request");
  a_read_upper_zero: assert property (ACK_O |-> DAT_O[31:8] == 24'h0)
    else $error("read data above bit 7");
  a_ier_readback: assert property (take && !WE_I && interrupt_control_register
    |=> DAT_O[7:1] == 7'h7e) else $error("control read wrong");
  a_unmapped_zero: assert property (take && !WE_I && ADR_I > 8'h27
    |=> DAT_O == 32'h0) else $error("unmapped read not zero");
  a_vec_answer: assert property (VEC_FETCH && !IRQ_N && !VEC_ACK
    |=> VEC_ACK) else $error("vector fetch not answered");
  a_vec_cause: assert property (VEC_ACK
    |-> $past(VEC_FETCH) && !$past(IRQ_N)) else $error("stray vector");
  a_vec_single: assert property (VEC_ACK |=> !VEC_ACK)
    else $error("vector ack too long");
  a_vec_quiet: assert property (!VEC_ACK |-> VEC_DATA == 8'h0)
    else $error("vector data outside fetch");
  a_irq_off_release: assert property (take && WE_I && SEL_I[0]
    && interrupt_control_register && !DAT_I[0] |=> ##[0:1] IRQ_N) else $error("request held");
endmodule : iie_top_chk

bind iie_top iie_top_chk #(.DB2_CYC(DB2_CYC), .DB3_CYC(DB3_CYC))
  i_iie_top_chk (.CLK(CLK), .RST_N(RST_N), .CYC_I(CYC_I),
  .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
  .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .IRQ_N(IRQ_N),
  .VEC_FETCH(VEC_FETCH), .VEC_DATA(VEC_DATA), .VEC_ACK(VEC_ACK));

// ===== test/iie_host.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Carrier interrupt responder
// ------------------------------------------------------------
module iie_host
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Bench control, dly slows the answer
  input  wire logic       go,
  input  wire logic [3:0] dly,
  // Vector fetch handshake
  input  wire logic       irq_n,
  input  wire logic       vec_ack,
  input  wire logic [7:0] vec_data,
  output logic            vec_fetch,
  output logic [7:0]      vec_got,
  output logic            done
);
  logic [3:0] wait_r;
  // Fetch only while a request is pending, hold until answered
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vec_fetch <= 1'b0;
      vec_got   <= 8'h00;
      done      <= 1'b0;
      wait_r    <= 4'h0;
    end
    else if (vec_fetch)
    begin
      if (vec_ack)
      begin
        vec_fetch <= 1'b0;
        vec_got   <= vec_data;
        done      <= 1'b1;
      end
    end
    else if (go && !irq_n && !done)
    begin
      if (wait_r == dly)
        vec_fetch <= 1'b1;
      else
        wait_r <= wait_r + 4'h1;
    end
    else if (!go)
    begin
      done   <= 1'b0;
      wait_r <= 4'h0;
    end
  end
endmodule : iie_host

// ===== test/tb_iie_top.sv
`timescale 1ns/1ps
module tb_iie_top;
  import iie_pkg::*;
  logic        clk, rst_n, cyc, stb, we, ack, irq_n;
  logic        vf, va, go, done;
  logic [7:0]  adr, vd, got;
  logic [3:0]  sel, dly;
  logic [31:0] dat, dat_o, lines, q;
  int          failures, total_checks;

  iie_top #(.DB2_CYC(40), .DB3_CYC(80)) i_iie_top (.CLK(clk),
    .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
    .SEL_I(sel), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack),
    .IN_LINES(lines), .IRQ_N(irq_n), .VEC_FETCH(vf), .VEC_DATA(vd),
    .VEC_ACK(va));
  iie_host i_iie_host (.clk(clk), .rst_n(rst_n), .go(go), .dly(dly),
    .irq_n(irq_n), .vec_ack(va), .vec_data(vd), .vec_fetch(vf),
    .vec_got(got), .done(done));

  // ------------------------------------------------------------
  // Clock and shared tasks
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
  begin
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  end
  endtask : chk

  task results;
  begin
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask : results

  // A spent wait counts as a mismatch and ends the run
  task timeout;
  begin
    failures++;
    results();
  end
  endtask : timeout

  // One classic cycle; answer taken at the rising edge that sees ack
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
  begin
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
      timeout();
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  end
  endtask : bus

  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] e);
  begin
    bus(1'b0, a, 8'h00);
    chk(q, e);
  end
  endtask : rd

  task irq_wait(input logic lvl);
    int n;
  begin
    n = 0;
    while (irq_n !== lvl && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, irq_n}, {31'h0, lvl});
    if (irq_n !== lvl)
      timeout();
    @(posedge clk);
  end
  endtask : irq_wait

  task rst;
  begin
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
  end
  endtask : rst

  task unlock;
  begin
    wr(OFS_PORT7, UNLOCK_B0);
    wr(OFS_PORT7, UNLOCK_B1);
    wr(OFS_PORT7, UNLOCK_B2);
    wr(OFS_PORT7, UNLOCK_B3);
  end
  endtask : unlock

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_std;
    int p;
  begin
    lines <= 32'h8421_c35a;
    for (p = 0; p < 4; p++)
      rd(8'(p * 4), {24'h0, 8'(32'h8421_c35a >> (8 * p))});
    wr(8'h04, 8'h0f);
    rd(8'h04, 32'h0000_00c0);
    wr(8'h04, 8'h00);
    rd(8'h04, 32'h0000_00c3);
    rd(8'h28, 32'h0);
  end
  endtask : t_std

  // Foreign access in mid unlock must abandon it
  task t_badunlock;
  begin
    wr(OFS_PORT7, UNLOCK_B0);
    wr(OFS_PORT7, UNLOCK_B1);
    rd(8'h00, 32'h5a);
    wr(OFS_PORT7, UNLOCK_B2);
    wr(OFS_PORT7, UNLOCK_B3);
    wr(OFS_PORT7, 8'h40);
    rd(8'h00, 32'h5a);
  end
  endtask : t_badunlock

  task t_events;
    int n;
  begin
    rst;
    unlock;
    lines <= 32'h10;
    wr(OFS_PORT7, 8'h40);
    wr(8'h18, 8'h02);
    wr(8'h00, 8'hff);
    wr(OFS_IVR, 8'ha5);
    wr(OFS_IER, 8'h01);
    chk({31'h0, irq_n}, 32'h1);
    lines <= 32'h11;
    irq_wait(1'b0);
    dly <= 4'h3;
    go  <= 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    if (done !== 1'b1)
      timeout();
    chk({24'h0, got}, 32'ha5);
    @(posedge clk);
    go <= 1'b0;
    rd(8'h00, 32'h01);
    wr(8'h00, 8'hfe);
    irq_wait(1'b1);
    wr(8'h00, 8'hff);
    rd(8'h00, 32'h00);
    lines <= 32'h01;
    irq_wait(1'b0);
    wr(OFS_IER, 8'h00);
    irq_wait(1'b1);
    rd(8'h00, 32'h10);
    wr(OFS_IER, 8'h03);
    rd(OFS_IER, 32'hfd);
    rd(OFS_IVR, 32'ha5);
    wr(OFS_PORT7, 8'h40);
    rd(8'h00, 32'h01);
    chk({31'h0, irq_n}, 32'h1);
  end
  endtask : t_events

  // Port 0 on the 80-cycle window, port 1 on the shortened third one
  task t_deb;
  begin
    rst;
    lines <= 32'h0;
    unlock;
    wr(OFS_PORT7, 8'h80);
    wr(8'h0c, 8'h01);
    wr(8'h04, 8'h08);
    wr(8'h00, 8'h03);
    wr(OFS_PORT7, 8'h00);
    lines <= 32'h0000_0102;
    repeat (20) @(posedge clk);
    rd(8'h00, 32'h00);
    rd(8'h04, 32'h00);
    repeat (30) @(posedge clk);
    rd(8'h04, 32'h01);
    rd(8'h00, 32'h00);
    repeat (40) @(posedge clk);
    rd(8'h00, 32'h02);
    wr(OFS_PORT7, 8'h01);
    wr(OFS_PORT7, 8'hc2);
    rd(OFS_PORT7, 32'h01);
    wr(8'h00, 8'h02);
    rd(8'h00, 32'h02);
  end
  endtask : t_deb

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    {cyc, stb, we, go} = 4'h0;
    adr = 8'h00;
    dat = 32'h0;
    sel = 4'h1;
    dly = 4'h0;
    lines = 32'h0;
    failures = 0;
    total_checks = 0;
    rst;
    t_std;
    t_badunlock;
    t_events;
    t_deb;
    results;
  end
endmodule : tb_iie_top
